// ==== design/mfs_frame_security.sv ====
// per-frame security controller: counters, mic sequencing, relay and key transport
// assumes an aes/mic engine on the same clock answering aes_req with aes_done
`timescale 1ns/1ns
module mfs_frame_security #(
  parameter int NBR_N = 8,
  parameter int IDX_W = $clog2(NBR_N),
  parameter logic [7:0] MAX_PAYLOAD = 8'h54
) (
  input wire logic clk, // 25 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic sec_enable, // security on
  input wire logic [63:0] own_addr, // own long source address
  input wire logic key_load, // pulse: new network key
  input wire logic [127:0] key_preset, // preset network key, zero means random
  input wire logic [127:0] key_random, // random network key candidate
  input wire logic link_load, // pulse: new trust link key
  input wire logic [127:0] link_preset, // preset link key, zero means random
  input wire logic [127:0] link_random, // random link key candidate
  input wire logic tx_req, // pulse: send request
  input wire logic [2:0] tx_kind, // frame kind code
  input wire logic tx_bcast, // broadcast destination
  input wire logic tx_e2e, // end-to-end security wanted
  input wire logic rx_req, // pulse: received frame
  input wire logic [IDX_W-1:0] rx_nbr, // sending neighbour index
  input wire logic [31:0] rx_fc, // received frame counter
  input wire logic [31:0] rx_mic_nwk, // received network mic
  input wire logic rx_aps, // received frame has end-to-end security
  input wire logic [31:0] rx_mic_aps, // received end-to-end mic
  input wire logic rx_is_dest, // this node is final destination
  input wire logic join_req, // pulse: joiner asks for network key
  input wire logic join_has_lk, // joiner holds preset link key
  input wire logic join_allow_clear, // policy allows key in clear
  input wire logic aes_done, // pulse: engine finished
  input wire logic [31:0] aes_mic, // engine mic result
  output logic busy, // controller not idle
  output logic aes_req, // pulse: start engine
  output logic aes_layer, // 0 network, 1 end-to-end
  output logic [127:0] aes_key, // key for engine
  output logic [31:0] aes_fc, // nonce counter for engine
  output logic tx_done, // pulse: frame ready to send
  output logic tx_refused, // pulse: send refused
  output logic [2:0] tx_reason, // refusal reason
  output logic [31:0] tx_fc_out, // counter placed in header
  output logic [63:0] tx_src_addr, // source address placed in header
  output logic tx_nwk_sec, // network security applied
  output logic tx_aps_sec, // end-to-end security applied
  output logic tx_relay, // frame is a relayed one
  output logic [31:0] tx_mic_nwk, // network mic to append
  output logic [31:0] tx_mic_aps, // end-to-end mic to append
  output logic [7:0] tx_overhead, // security overhead bytes
  output logic [7:0] tx_max_payload, // payload limit for this frame
  output logic rx_accept, // pulse: frame accepted
  output logic rx_drop, // pulse: frame dropped
  output logic [2:0] rx_reason, // drop reason
  output logic rx_strip_aps, // end-to-end layer removed here
  output logic join_done, // pulse: key transport issued
  output logic join_encrypted, // key wrapped in link key
  output logic join_refused, // pulse: joiner refused
  output logic [31:0] fc // own frame counter
);
  mfs_pkg::mfs_state_t state, next_state;
  logic [127:0] net_key, next_net_key, link_key, next_link_key;
  logic [31:0] next_fc, cur_fc, next_cur_fc, cur_mic_nwk, next_cur_mic_nwk;
  logic [31:0] cur_mic_aps, next_cur_mic_aps;
  logic [IDX_W-1:0] cur_nbr, next_cur_nbr;
  logic cur_aps, next_cur_aps, cur_dest, next_cur_dest, cur_relay, next_cur_relay;
  logic next_aes_req, next_aes_layer, next_busy;
  logic [127:0] next_aes_key;
  logic [31:0] next_aes_fc;
  logic next_tx_done, next_tx_refused, next_tx_nwk_sec, next_tx_aps_sec, next_tx_relay;
  logic [2:0] next_tx_reason, next_rx_reason;
  logic [31:0] next_tx_fc_out, next_tx_mic_nwk, next_tx_mic_aps;
  logic [63:0] next_tx_src_addr;
  logic [7:0] next_tx_overhead, next_tx_max_payload, ovh;
  logic next_rx_accept, next_rx_drop, next_rx_strip_aps;
  logic next_join_done, next_join_encrypted, next_join_refused;
  logic nwk_pass;

  mfs_nbr_if #(.IDX_W(IDX_W)) nbr_bus();

  mfs_nbr_table #(.NBR_N(NBR_N)) u_nbr (
    .clk(clk),
    .reset_n(reset_n),
    .nbr(nbr_bus.owner)
  );

  assign nwk_pass = (state == mfs_pkg::ST_RX_NWK) && aes_done && (aes_mic == cur_mic_nwk);
  assign nbr_bus.ce = ce;
  assign nbr_bus.idx = (state == mfs_pkg::ST_IDLE) ? rx_nbr : cur_nbr;
  assign nbr_bus.fc = (state == mfs_pkg::ST_IDLE) ? rx_fc : cur_fc;
  assign nbr_bus.clr = key_load;
  assign nbr_bus.upd = nwk_pass && !key_load;
  assign ovh = mfs_pkg::NWK_OVH + (cur_aps ? mfs_pkg::APS_OVH : 8'h00);

  always_comb begin
    next_state = state;
    next_fc = fc;
    next_net_key = net_key;
    next_link_key = link_key;
    next_cur_fc = cur_fc;
    next_cur_mic_nwk = cur_mic_nwk;
    next_cur_mic_aps = cur_mic_aps;
    next_cur_nbr = cur_nbr;
    next_cur_aps = cur_aps;
    next_cur_dest = cur_dest;
    next_cur_relay = cur_relay;
    next_aes_req = 1'b0;
    next_aes_layer = aes_layer;
    next_aes_key = aes_key;
    next_aes_fc = aes_fc;
    next_tx_done = 1'b0;
    next_tx_refused = 1'b0;
    next_tx_reason = tx_reason;
    next_tx_fc_out = tx_fc_out;
    next_tx_src_addr = tx_src_addr;
    next_tx_nwk_sec = tx_nwk_sec;
    next_tx_aps_sec = tx_aps_sec;
    next_tx_relay = tx_relay;
    next_tx_mic_nwk = tx_mic_nwk;
    next_tx_mic_aps = tx_mic_aps;
    next_tx_overhead = tx_overhead;
    next_tx_max_payload = tx_max_payload;
    next_rx_accept = 1'b0;
    next_rx_drop = 1'b0;
    next_rx_reason = rx_reason;
    next_rx_strip_aps = rx_strip_aps;
    next_join_done = 1'b0;
    next_join_encrypted = join_encrypted;
    next_join_refused = 1'b0;
    if (link_load) begin
      next_link_key = (link_preset == mfs_pkg::KEY_RST) ? link_random : link_preset;
    end
    if (key_load) begin
      next_net_key = (key_preset == mfs_pkg::KEY_RST) ? key_random : key_preset;
      next_fc = mfs_pkg::FC_RST;
      next_state = mfs_pkg::ST_IDLE;
    end else begin
      case (state)
        mfs_pkg::ST_IDLE: begin
          if (rx_req) begin
            next_cur_nbr = rx_nbr;
            next_cur_fc = rx_fc;
            next_cur_mic_nwk = rx_mic_nwk;
            next_cur_mic_aps = rx_mic_aps;
            next_cur_aps = rx_aps;
            next_cur_dest = rx_is_dest;
            next_rx_strip_aps = 1'b0;
            if (!sec_enable) begin
              next_rx_accept = 1'b1;
              next_rx_reason = mfs_pkg::RSN_NONE;
            end else if (nbr_bus.stale) begin
              next_rx_drop = 1'b1;
              next_rx_reason = mfs_pkg::RSN_REPLAY;
            end else begin
              next_aes_req = 1'b1;
              next_aes_layer = mfs_pkg::LAYER_NWK;
              next_aes_key = net_key;
              next_aes_fc = rx_fc;
              next_state = mfs_pkg::ST_RX_NWK;
            end
          end else if (tx_req) begin
            next_cur_aps = tx_e2e;
            next_cur_relay = 1'b0;
            if (!sec_enable || tx_kind == mfs_pkg::KIND_MAC) begin
              next_tx_done = 1'b1;
              next_tx_nwk_sec = 1'b0;
              next_tx_aps_sec = 1'b0;
              next_tx_relay = 1'b0;
              next_tx_overhead = 8'h00;
              next_tx_max_payload = MAX_PAYLOAD;
              next_tx_reason = mfs_pkg::RSN_NONE;
            end else if (tx_e2e && tx_bcast) begin
              next_tx_refused = 1'b1;
              next_tx_reason = mfs_pkg::RSN_BCAST_E2E;
            end else if (fc == mfs_pkg::FC_MAX) begin
              next_tx_refused = 1'b1;
              next_tx_reason = mfs_pkg::RSN_EXHAUST;
            end else if (tx_e2e) begin
              next_aes_req = 1'b1;
              next_aes_layer = mfs_pkg::LAYER_APS;
              next_aes_key = link_key;
              next_aes_fc = fc;
              next_state = mfs_pkg::ST_TX_APS;
            end else begin
              // network key on every data frame
              next_aes_req = 1'b1;
              next_aes_layer = mfs_pkg::LAYER_NWK;
              next_aes_key = net_key;
              next_aes_fc = fc;
              next_state = mfs_pkg::ST_TX_NWK;
            end
          end else if (join_req) begin
            // wrap key for link key holders
            if (join_has_lk) begin
              next_join_done = 1'b1;
              next_join_encrypted = 1'b1;
            end else if (join_allow_clear) begin
              next_join_done = 1'b1;
              next_join_encrypted = 1'b0;
            end else begin
              next_join_refused = 1'b1;
            end
          end
        end
        mfs_pkg::ST_TX_APS: begin
          if (aes_done) begin
            next_tx_mic_aps = aes_mic;
            next_aes_req = 1'b1;
            next_aes_layer = mfs_pkg::LAYER_NWK;
            next_aes_key = net_key;
            next_aes_fc = fc;
            next_state = mfs_pkg::ST_TX_NWK;
          end
        end
        mfs_pkg::ST_TX_NWK: begin
          if (aes_done) begin
            next_tx_mic_nwk = aes_mic;
            next_tx_done = 1'b1;
            next_tx_fc_out = fc;
            next_tx_src_addr = own_addr;
            next_tx_nwk_sec = 1'b1;
            next_tx_aps_sec = cur_aps;
            next_tx_relay = cur_relay;
            next_tx_overhead = ovh;
            next_tx_max_payload = MAX_PAYLOAD - ovh;
            next_tx_reason = mfs_pkg::RSN_NONE;
            next_fc = fc + mfs_pkg::FC_STEP;
            next_state = mfs_pkg::ST_IDLE;
          end
        end
        mfs_pkg::ST_RX_NWK: begin
          if (aes_done) begin
            if (!nwk_pass) begin
              next_rx_drop = 1'b1;
              next_rx_reason = mfs_pkg::RSN_MIC_NWK;
              next_state = mfs_pkg::ST_IDLE;
            end else if (cur_dest && cur_aps) begin
              next_aes_req = 1'b1;
              next_aes_layer = mfs_pkg::LAYER_APS;
              next_aes_key = link_key;
              next_aes_fc = cur_fc;
              next_state = mfs_pkg::ST_RX_APS;
            end else begin
              next_rx_accept = 1'b1;
              next_rx_reason = mfs_pkg::RSN_NONE;
              next_state = mfs_pkg::ST_IDLE;
              if (!cur_dest) begin
                next_cur_relay = 1'b1;
                if (fc == mfs_pkg::FC_MAX) begin
                  next_tx_refused = 1'b1;
                  next_tx_reason = mfs_pkg::RSN_EXHAUST;
                end else begin
                  next_aes_req = 1'b1;
                  next_aes_layer = mfs_pkg::LAYER_NWK;
                  next_aes_key = net_key;
                  next_aes_fc = fc;
                  next_state = mfs_pkg::ST_TX_NWK;
                end
              end
            end
          end
        end
        mfs_pkg::ST_RX_APS: begin
          if (aes_done) begin
            next_state = mfs_pkg::ST_IDLE;
            if (aes_mic != cur_mic_aps) begin
              next_rx_drop = 1'b1;
              next_rx_reason = mfs_pkg::RSN_MIC_APS;
            end else begin
              next_rx_accept = 1'b1;
              next_rx_strip_aps = 1'b1;
              next_rx_reason = mfs_pkg::RSN_NONE;
            end
          end
        end
        default: next_state = mfs_pkg::ST_IDLE;
      endcase
    end
    next_busy = (next_state != mfs_pkg::ST_IDLE);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= mfs_pkg::ST_IDLE;
      fc <= 32'h0;
      net_key <= 128'h0;
      link_key <= 128'h0;
      cur_fc <= 32'h0;
      cur_mic_nwk <= 32'h0;
      cur_mic_aps <= 32'h0;
      cur_nbr <= '0;
      cur_aps <= 1'b0;
      cur_dest <= 1'b0;
      cur_relay <= 1'b0;
      busy <= 1'b0;
      aes_req <= 1'b0;
      aes_layer <= 1'b0;
      aes_key <= 128'h0;
      aes_fc <= 32'h0;
      tx_done <= 1'b0;
      tx_refused <= 1'b0;
      tx_reason <= 3'h0;
      tx_fc_out <= 32'h0;
      tx_src_addr <= 64'h0;
      tx_nwk_sec <= 1'b0;
      tx_aps_sec <= 1'b0;
      tx_relay <= 1'b0;
      tx_mic_nwk <= 32'h0;
      tx_mic_aps <= 32'h0;
      tx_overhead <= 8'h0;
      tx_max_payload <= 8'h0;
      rx_accept <= 1'b0;
      rx_drop <= 1'b0;
      rx_reason <= 3'h0;
      rx_strip_aps <= 1'b0;
      join_done <= 1'b0;
      join_encrypted <= 1'b0;
      join_refused <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      fc <= next_fc;
      net_key <= next_net_key;
      link_key <= next_link_key;
      cur_fc <= next_cur_fc;
      cur_mic_nwk <= next_cur_mic_nwk;
      cur_mic_aps <= next_cur_mic_aps;
      cur_nbr <= next_cur_nbr;
      cur_aps <= next_cur_aps;
      cur_dest <= next_cur_dest;
      cur_relay <= next_cur_relay;
      busy <= next_busy;
      aes_req <= next_aes_req;
      aes_layer <= next_aes_layer;
      aes_key <= next_aes_key;
      aes_fc <= next_aes_fc;
      tx_done <= next_tx_done;
      tx_refused <= next_tx_refused;
      tx_reason <= next_tx_reason;
      tx_fc_out <= next_tx_fc_out;
      tx_src_addr <= next_tx_src_addr;
      tx_nwk_sec <= next_tx_nwk_sec;
      tx_aps_sec <= next_tx_aps_sec;
      tx_relay <= next_tx_relay;
      tx_mic_nwk <= next_tx_mic_nwk;
      tx_mic_aps <= next_tx_mic_aps;
      tx_overhead <= next_tx_overhead;
      tx_max_payload <= next_tx_max_payload;
      rx_accept <= next_rx_accept;
      rx_drop <= next_rx_drop;
      rx_reason <= next_rx_reason;
      rx_strip_aps <= next_rx_strip_aps;
      join_done <= next_join_done;
      join_encrypted <= next_join_encrypted;
      join_refused <= next_join_refused;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_FC_INC: assert property (tx_done && tx_nwk_sec |-> fc == tx_fc_out + 32'h1)
    else $error("counter not bumped after secured send");
  AST_FC_HOLD: assert property (ce && !key_load && fc == mfs_pkg::FC_MAX
    |=> fc == mfs_pkg::FC_MAX)
    else $error("exhausted counter moved");
  AST_KEY_CLR: assert property (ce && key_load |=> fc == 32'h0 && !busy)
    else $error("counter not cleared on key change");
  AST_REPLAY: assert property (ce && !key_load && state == mfs_pkg::ST_IDLE && rx_req
    && sec_enable && nbr_bus.stale |=> rx_drop && rx_reason == mfs_pkg::RSN_REPLAY)
    else $error("replayed frame not dropped");
  AST_MIC_NWK: assert property (ce && !key_load && state == mfs_pkg::ST_RX_NWK && aes_done
    && aes_mic != cur_mic_nwk |=> rx_drop && rx_reason == mfs_pkg::RSN_MIC_NWK)
    else $error("bad network mic not dropped");
  AST_OVH: assert property (tx_done && tx_nwk_sec |-> tx_overhead ==
    (tx_aps_sec ? 8'h1b : 8'h12) && tx_max_payload == MAX_PAYLOAD - tx_overhead)
    else $error("wrong security overhead");
  AST_BCAST: assert property (ce && !key_load && state == mfs_pkg::ST_IDLE && !rx_req
    && tx_req && sec_enable && tx_kind != mfs_pkg::KIND_MAC && tx_e2e && tx_bcast
    |=> tx_refused && !aes_req)
    else $error("end-to-end applied to broadcast");
  AST_BEACON: assert property (ce && !key_load && state == mfs_pkg::ST_IDLE && !rx_req
    && tx_req && tx_kind == mfs_pkg::KIND_MAC |=> tx_done && !tx_nwk_sec)
    else $error("mac frame was secured");
  AST_ORDER: assert property (ce && !key_load && state == mfs_pkg::ST_TX_APS && aes_done
    |=> state == mfs_pkg::ST_TX_NWK && aes_req && aes_layer == mfs_pkg::LAYER_NWK)
    else $error("network layer not applied after end-to-end");
  AST_NO_EXH: assert property (tx_done && tx_nwk_sec |-> $past(fc) != mfs_pkg::FC_MAX)
    else $error("secured send with exhausted counter");
  AST_JOIN: assert property (ce && !key_load && state == mfs_pkg::ST_IDLE && !rx_req
    && !tx_req && join_req && join_has_lk |=> join_done && join_encrypted)
    else $error("key not wrapped for link key holder");

  COV_E2E_TX: cover property (tx_done && tx_aps_sec);
  COV_RELAY: cover property (tx_done && tx_relay);
  COV_REPLAY: cover property (rx_drop && rx_reason == mfs_pkg::RSN_REPLAY);
  COV_STRIP: cover property (rx_accept && rx_strip_aps);
endmodule

// ==== pkg/mfs_pkg.sv ====
// constants, codes and state encoding for the mesh frame security block
// assumes one 25 MHz clock and an external aes engine on the same clock
// How it works
// - own 32-bit counter, sent, bumped per secured send
// - drop frames older than neighbour's last counter
// - counter saturates at 0x0fffffff, secured sends refused
// - new network key zeroes all counters
// - network mic over headers and payload appended
// - network mic mismatch drops the frame
// - relay decrypts, re-secures with own counter
// - network security adds eighteen bytes overhead
// - routing, commands secured; mac frames never
// - secure every data frame with network key
// - end-to-end per frame, never on broadcast
// - end-to-end only source/destination, nine bytes
// - end-to-end mic mismatch drops at destination
// - joiner with link key gets wrapped key
// - policy decides clear key for others
// - coordinator picks preset or random keys
package mfs_pkg;
  localparam int FC_W = 32;
  localparam logic [31:0] FC_RST = 32'h0;
  localparam logic [31:0] FC_MAX = 32'h0fffffff;
  localparam logic [31:0] FC_STEP = 32'h1;
  localparam logic [127:0] KEY_RST = 128'h0;
  localparam logic [7:0] FC_BYTES = 8'h04;
  localparam logic [7:0] SRC_BYTES = 8'h08;
  localparam logic [7:0] MIC_BYTES = 8'h04;
  localparam logic [7:0] OTHER_BYTES = 8'h02;
  localparam logic [7:0] APS_HDR_BYTES = 8'h05;
  localparam logic [7:0] NWK_OVH = FC_BYTES + SRC_BYTES + MIC_BYTES + OTHER_BYTES;
  localparam logic [7:0] APS_OVH = APS_HDR_BYTES + MIC_BYTES;

  typedef enum logic [2:0] {
    KIND_DATA = 3'h0,
    KIND_ROUTE = 3'h1,
    KIND_APS_CMD = 3'h2,
    KIND_ZDO_CMD = 3'h3,
    KIND_MAC = 3'h4
  } mfs_kind_t;

  typedef enum logic {
    LAYER_NWK = 1'b0,
    LAYER_APS = 1'b1
  } mfs_layer_t;

  typedef enum logic [2:0] {
    RSN_NONE = 3'h0,
    RSN_REPLAY = 3'h1,
    RSN_MIC_NWK = 3'h2,
    RSN_MIC_APS = 3'h3,
    RSN_EXHAUST = 3'h4,
    RSN_BCAST_E2E = 3'h5
  } mfs_reason_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TX_APS = 3'b001,
    ST_TX_NWK = 3'b011,
    ST_RX_NWK = 3'b100,
    ST_RX_APS = 3'b101
  } mfs_state_t;
endpackage

// ==== pkg/mfs_nbr_if.sv ====
// carrier between the security controller and its neighbour counter table
// assumes the controller drives every field combinationally on the same clock
`timescale 1ns/1ns
interface mfs_nbr_if #(parameter int IDX_W = 3);
  logic ce;
  logic [IDX_W-1:0] idx;
  logic [31:0] fc;
  logic upd;
  logic clr;
  logic stale;
  modport owner(input ce, idx, fc, upd, clr, output stale);
  modport user(output ce, idx, fc, upd, clr, input stale);
endinterface

// ==== design/mfs_nbr_table.sv ====
// last-seen frame counter per neighbour, with replay compare
// assumes the controller holds idx and fc stable while upd is high
`timescale 1ns/1ns
module mfs_nbr_table #(
  parameter int NBR_N = 8
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  mfs_nbr_if.owner nbr // lookup, update and clear
);
  logic [31:0] seen [NBR_N];
  logic [31:0] next_seen [NBR_N];

  assign nbr.stale = nbr.fc < seen[nbr.idx];

  always_comb begin
    next_seen = seen;
    if (nbr.clr) begin
      for (int i = 0; i < NBR_N; i++) begin
        next_seen[i] = mfs_pkg::FC_RST;
      end
    end else if (nbr.upd) begin
      next_seen[nbr.idx] = nbr.fc;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NBR_N; i++) begin
        seen[i] <= 32'h0;
      end
    end else if (nbr.ce) begin
      seen <= next_seen;
    end
  end

  AST_NBR_UPD: assert property (@(posedge clk) disable iff (!reset_n)
    nbr.ce && nbr.upd && !nbr.clr |=> seen[$past(nbr.idx)] == $past(nbr.fc))
    else $error("neighbour counter not recorded");
  AST_NBR_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    nbr.ce && nbr.clr |=> seen[0] == 32'h0 && seen[NBR_N-1] == 32'h0)
    else $error("neighbour counters not cleared on key change");
endmodule

// ==== verification/mfs_aes_model.sv ====
// engine stand-in answering aes_req with one aes_done and a keyed mic
// assumes requests are one-cycle pulses on clk with fields held meanwhile
`timescale 1ns/1ns
module mfs_aes_model (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic slow, // long answer when high
  input wire logic aes_req, // start pulse
  input wire logic aes_layer, // 0 network, 1 end-to-end
  input wire logic [127:0] aes_key, // key in use
  input wire logic [31:0] aes_fc, // nonce counter
  output logic aes_done, // finish pulse
  output logic [31:0] aes_mic // valid with aes_done only
);
  logic [3:0] cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 4'h0;
      aes_done <= 1'b0;
      aes_mic <= 32'h0;
    end else begin
      aes_done <= (cnt == 4'h1);
      aes_mic <= (cnt == 4'h1) ? aes_key[31:0] ^ (aes_layer ? 32'h5a5a5a5a : aes_fc) : ~aes_mic;
      if (aes_req) cnt <= slow ? 4'h6 : 4'h1;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
endmodule

// ==== verification/mfs_frame_security_tb.sv ====
// self-checking bench for the frame security controller
// assumes a 25 MHz clock and the engine stand-in beside the design
`timescale 1ns/1ns
module mfs_frame_security_tb;
  typedef struct {logic en; logic [2:0] kind; logic bc, e2e, ok, ns, as; logic [7:0] ovh;
    logic [2:0] rsn;} mfs_row_t;
  logic clk, reset_n, sec_enable, key_load, link_load, tx_req, tx_bcast, tx_e2e, rx_req;
  logic rx_aps, rx_is_dest, join_req, join_has_lk, join_allow_clear, slow, aes_done, aes_req;
  logic aes_layer, busy, tx_done, tx_refused, tx_nwk_sec, tx_aps_sec, tx_relay, rx_accept;
  logic rx_drop, join_done, join_encrypted, join_refused;
  logic [2:0] tx_kind, rx_nbr, tx_reason, rx_reason;
  logic [7:0] tx_overhead, tx_max_payload;
  logic [31:0] rx_fc, rx_mic_nwk, rx_mic_aps, aes_mic, aes_fc, tx_fc_out, tx_mic_nwk, fc, efc;
  logic [63:0] own_addr, tx_src_addr;
  logic [127:0] key_preset, link_preset, aes_key, key_random;
  logic [31:0] tx_mic_aps;
  logic rx_strip_aps;
  logic [5:0] got;
  int miscompares = 0, n_compared = 0;
  mfs_row_t rows [8];
  mfs_frame_security mfs_frame_security_i (.clk, .reset_n, .ce(1'b1), .sec_enable, .own_addr,
    .key_load, .key_preset, .key_random, .link_load, .link_preset,
    .link_random(128'h0), .tx_req, .tx_kind, .tx_bcast, .tx_e2e, .rx_req, .rx_nbr, .rx_fc,
    .rx_mic_nwk, .rx_aps, .rx_mic_aps, .rx_is_dest, .join_req, .join_has_lk,
    .join_allow_clear, .aes_done, .aes_mic, .busy, .aes_req, .aes_layer, .aes_key, .aes_fc,
    .tx_done, .tx_refused, .tx_reason, .tx_fc_out, .tx_src_addr, .tx_nwk_sec, .tx_aps_sec,
    .tx_relay, .tx_mic_nwk, .tx_mic_aps, .tx_overhead, .tx_max_payload, .rx_accept,
    .rx_drop, .rx_reason, .rx_strip_aps, .join_done, .join_encrypted, .join_refused, .fc);
  mfs_aes_model mfs_aes_model_i (.clk, .reset_n, .slow, .aes_req, .aes_layer, .aes_key,
    .aes_fc, .aes_done, .aes_mic);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] emic(logic [127:0] k, logic [31:0] f, logic l);
    return k[31:0] ^ (l ? 32'h5a5a5a5a : f);
  endfunction
  task automatic chk(input logic [63:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic go(input logic t, r, j);
    @(negedge clk) {tx_req, rx_req, join_req} = {t, r, j};
    @(negedge clk) {tx_req, rx_req, join_req} = 3'h0;
    got = {join_refused, join_done, rx_drop, rx_accept, tx_refused, tx_done};
    for (int i = 0; i < 40 && (busy !== 1'b0 || got == 6'h0); i++) begin
      @(negedge clk);
      got |= {join_refused, join_done, rx_drop, rx_accept, tx_refused, tx_done};
    end
  endtask
  task automatic rx(input logic [31:0] f, input logic bad, input logic [2:0] r);
    rx_fc = f;
    rx_mic_nwk = emic(key_preset | key_random, f, 1'b0) ^ {31'h0, bad};
    go(1'b0, 1'b1, 1'b0);
    chk({got[3:2], rx_reason}, {r != 3'h0, r == 3'h0, r}, "rx outcome");
  endtask
  task automatic close_out();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    close_out();
  end
  initial begin
    {sec_enable, key_load, link_load, tx_req, tx_bcast, tx_e2e, rx_req, rx_aps} = 8'h0;
    {rx_is_dest, join_req, join_has_lk, join_allow_clear, slow, tx_kind} = 8'h0;
    {rx_nbr, rx_fc, rx_mic_nwk, rx_mic_aps} = '0;
    own_addr = 64'h0123456789abcdef;
    key_preset = {4{32'h1234abcd}};
    link_preset = {4{32'h0badf00d}};
    key_random = 128'h0;
    rows = '{'{1, 0, 0, 1, 1, 1, 1, 8'h1b, 0}, '{0, 0, 0, 1, 1, 0, 0, 0, 0},
      '{1, 4, 1, 0, 1, 0, 0, 0, 0}, '{1, 0, 0, 0, 1, 1, 0, 8'h12, 0},
      '{1, 1, 1, 0, 1, 1, 0, 8'h12, 0}, '{1, 2, 0, 0, 1, 1, 0, 8'h12, 0},
      '{1, 3, 0, 0, 1, 1, 0, 8'h12, 0}, '{1, 0, 1, 1, 0, 0, 0, 0, 3'h5}};
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    @(negedge clk) {key_load, link_load} = 2'h3;
    @(negedge clk) {key_load, link_load} = 2'h0;
    efc = 32'h0;
    foreach (rows[k]) begin
      {sec_enable, tx_kind, tx_bcast, tx_e2e} = {rows[k].en, rows[k].kind, rows[k].bc, rows[k].e2e};
      slow = k[0];
      go(1'b1, 1'b0, 1'b0);
      chk(got[1:0], {!rows[k].ok, rows[k].ok}, "tx outcome");
      if (rows[k].ok) begin
        chk({tx_nwk_sec, tx_aps_sec, tx_overhead, tx_max_payload}, {rows[k].ns, rows[k].as,
          rows[k].ovh, 8'h54 - rows[k].ovh}, "tx fields");
        if (rows[k].ns) chk({tx_fc_out, tx_mic_nwk}, {efc, emic(key_preset, efc, 1'b0)}, "tx mic");
        if (rows[k].as) chk(tx_mic_aps, emic(link_preset, efc, 1'b1), "tx e2e mic");
        if (rows[k].ns) efc++;
      end else chk(tx_reason, rows[k].rsn, "tx reason");
      chk(fc, efc, "own count");
    end
    $display("tx rows done");
    {sec_enable, rx_nbr, rx_is_dest} = {1'b1, 3'h1, 1'b1};
    rx(32'ha, 1'b0, 3'h0);
    rx(32'h9, 1'b0, 3'h1);
    rx(32'ha, 1'b0, 3'h0);
    rx(32'hb, 1'b1, 3'h2);
    rx_aps = 1'b1;
    rx_mic_aps = emic(link_preset, 32'h0, 1'b1) ^ 32'h1;
    rx(32'hc, 1'b0, 3'h3);
    rx_mic_aps = emic(link_preset, 32'h0, 1'b1);
    rx(32'hd, 1'b0, 3'h0);
    chk(rx_strip_aps, 1'b1, "strip at destination");
    rx_is_dest = 1'b0;
    rx(32'he, 1'b0, 3'h0);
    chk({got[0], tx_relay, tx_aps_sec, rx_strip_aps, tx_fc_out}, {4'he, efc}, "relay");
    chk(tx_src_addr, own_addr, "relay source");
    $display("rx tests done");
    {rx_is_dest, rx_aps} = 2'h2;
    {key_preset, key_random} = {128'h0, {4{32'h5eed1234}}};
    @(negedge clk) key_load = 1'b1;
    @(negedge clk) key_load = 1'b0;
    chk(fc, 64'h0, "count after key");
    rx(32'h0, 1'b0, 3'h0);
    for (int j = 0; j < 3; j++) begin
      {join_has_lk, join_allow_clear} = {j == 0, j == 1};
      go(1'b0, 1'b0, 1'b1);
      chk({got[5:4], join_encrypted & (j < 2)}, {j == 2, j < 2, j == 0}, "join");
    end
    {tx_bcast, tx_e2e} = 2'h0;
    go(1'b1, 1'b0, 1'b0);
    chk({tx_fc_out, fc}, {32'h0, 32'h1}, "send after key");
    $display("key and join tests done");
    @(negedge clk) reset_n = 1'b0;
    #1 chk({busy, fc}, 64'h0, "mid-run reset");
    @(negedge clk) reset_n = 1'b1;
    close_out();
  end
endmodule
